// [hw/bst_pkg.sv]
// package for the boundary-scan test port: codes, widths, states, carriers
package bst_pkg;
   localparam int unsigned IR_W        = 3;              // instruction width
   localparam int unsigned ID_W        = 32;             // identification width
   localparam int unsigned BSR_W       = 8;              // boundary chain length stand-in
   localparam logic [2:0]  IR_CAPTURE  = 3'h1;           // capture pattern, low bits 01
   localparam logic [2:0]  INS_EXTEST  = 3'h0;           // drive preloaded data
   localparam logic [2:0]  INS_IDCODE  = 3'h1;           // identification select
   localparam logic [2:0]  INS_SAMPZ   = 3'h2;           // sample with outputs off
   localparam logic [2:0]  INS_SAMPLE  = 3'h4;           // sample / preload
   localparam logic [2:0]  INS_BYPASS  = 3'h7;           // bypass select
   localparam logic [31:0] ID_CODE     = 32'h0000_0001;  // arbitrary value, lsb fixed one
   localparam logic        SYNC_RST    = 1'b0;           // synchroniser reset value
   localparam logic        BYP_CAPTURE = 1'b0;           // bypass captures low
   localparam logic [2:0]  RST_HIGHS   = 3'h5;           // mode-select-high edges forcing reset

   // controller states, binary codes written out
   typedef enum logic [3:0] {
      ST_RESET = 4'h0, ST_IDLE  = 4'h1, ST_SELDR = 4'h2, ST_CAPDR = 4'h3,
      ST_SHDR  = 4'h4, ST_EX1DR = 4'h5, ST_PADR  = 4'h6, ST_EX2DR = 4'h7,
      ST_UPDR  = 4'h8, ST_SELIR = 4'h9, ST_CAPIR = 4'hA, ST_SHIR  = 4'hB,
      ST_EX1IR = 4'hC, ST_PAIR  = 4'hD, ST_EX2IR = 4'hE, ST_UPIR  = 4'hF
   } bst_state_e;

   // test pins as seen by the block
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bst_pins_s;
endpackage

// [hw/bst_tap.sv]
// boundary-scan test access port controller with its data registers
// How it works
// - controller logic steps only on test clock edges; synchronisers step on every core clock
// - inputs sampled at test clock rising edge
// - serial output and its enable launched at test clock falling edge
// - state follows mode select each rising edge
// - floating mode select reads as high
// - floating serial input reads as high
// - instruction picks exactly one data register
// - serial input shifts into register msb
// - serial output taken from register lsb
// - output driver enabled only when needed
// - five mode-select-high edges force reset
// - test reset leaves memory untouched
// - power-up reset, output starts tristated
// - unclocked port stays in reset harmlessly
// - full standard controller state machine
// - three-bit instruction, identify after reset
// - capture-instruction loads 01 into low bits
// - one-bit bypass, one stage delay
// - identify captures and shifts 32-bit code
`timescale 1ns/1ps
`default_nettype none
module bst_tap (
   input  wire logic                      core_clk,    // sampling clock
   input  wire logic                      rst_n,       // power-up reset, async low
   input  wire bst_pkg::bst_pins_s        pins,        // raw test pins
   input  wire logic                      tms_driven,  // mode select pad actively driven
   input  wire logic                      tdi_driven,  // serial in pad actively driven
   input  wire logic [bst_pkg::BSR_W-1:0] bsr_pins,    // pin ring snapshot
   output logic                           tdo_o,       // serial data out value
   output logic                           tdo_oe,      // serial data out enable
   output logic [bst_pkg::IR_W-1:0]       instr,       // active instruction
   output logic                           outs_off,    // request memory outputs high z
   output logic [bst_pkg::BSR_W-1:0]      bsr_out      // preloaded pattern for extest
);
   // two-flop synchronisers; first stage read only by second stage
   logic [2:0] s1_reg, s1_next, s2_reg, s2_next;
   logic       tck_d_reg, tck_d_next;              // previous synced clock level
   bst_pkg::bst_state_e st_reg, st_next;           // controller state
   logic [bst_pkg::IR_W-1:0]  ir_sh_reg, ir_sh_next, ir_reg, ir_next;
   logic [bst_pkg::ID_W-1:0]  id_reg, id_next;     // identification shifter
   logic                      byp_reg, byp_next;   // bypass stage
   logic [bst_pkg::BSR_W-1:0] bs_reg, bs_next, pre_reg, pre_next;
   logic tdo_reg, tdo_next, oe_reg, oe_next;       // falling-edge launched outputs
   logic rise, fall, tms_s, tdi_s;
   // pin ring crosses from the memory clocks; each bit synchronised on its own,
   // so a ring that moves during capture may be caught half old, half new
   logic [bst_pkg::BSR_W-1:0] b1_reg, b1_next, b2_reg, b2_next;

   // synchroniser next values; pull-ups make undriven pads read high
   always_comb begin
      s1_next = {pins.tck, pins.tms | ~tms_driven, pins.tdi | ~tdi_driven};
      s2_next = s1_reg;
      tck_d_next = s2_reg[2];
      b1_next = bsr_pins;
      b2_next = b1_reg;
   end

   // sampling flops; reset values are constants only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         tck_d_reg <= bst_pkg::SYNC_RST;
         b1_reg    <= '0;
         b2_reg    <= '0;
      end else begin
         s1_reg    <= s1_next;
         s2_reg    <= s2_next;
         tck_d_reg <= tck_d_next;
         b1_reg    <= b1_next;
         b2_reg    <= b2_next;
      end
   end

   // edges of the test clock; nothing advances without one
   assign rise  = s2_reg[2] & ~tck_d_reg;
   assign fall  = ~s2_reg[2] & tck_d_reg;
   assign tms_s = s2_reg[1];
   assign tdi_s = s2_reg[0];

   // standard sixteen-state walk
   function automatic bst_pkg::bst_state_e nxt(input bst_pkg::bst_state_e s, input logic m);
      case (s)
         bst_pkg::ST_RESET: nxt = m ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:  nxt = m ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SELDR: nxt = m ? bst_pkg::ST_SELIR : bst_pkg::ST_CAPDR;
         bst_pkg::ST_CAPDR: nxt = m ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
         bst_pkg::ST_SHDR:  nxt = m ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
         bst_pkg::ST_EX1DR: nxt = m ? bst_pkg::ST_UPDR  : bst_pkg::ST_PADR;
         bst_pkg::ST_PADR:  nxt = m ? bst_pkg::ST_EX2DR : bst_pkg::ST_PADR;
         bst_pkg::ST_EX2DR: nxt = m ? bst_pkg::ST_UPDR  : bst_pkg::ST_SHDR;
         bst_pkg::ST_UPDR:  nxt = m ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SELIR: nxt = m ? bst_pkg::ST_RESET : bst_pkg::ST_CAPIR;
         bst_pkg::ST_CAPIR: nxt = m ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
         bst_pkg::ST_SHIR:  nxt = m ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
         bst_pkg::ST_EX1IR: nxt = m ? bst_pkg::ST_UPIR  : bst_pkg::ST_PAIR;
         bst_pkg::ST_PAIR:  nxt = m ? bst_pkg::ST_EX2IR : bst_pkg::ST_PAIR;
         bst_pkg::ST_EX2IR: nxt = m ? bst_pkg::ST_UPIR  : bst_pkg::ST_SHIR;
         bst_pkg::ST_UPIR:  nxt = m ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
         default:           nxt = bst_pkg::ST_RESET;
      endcase
   endfunction

   // controller and registers, all stepping at rising test clock
   always_comb begin
      st_next    = st_reg;
      ir_sh_next = ir_sh_reg;
      ir_next    = ir_reg;
      id_next    = id_reg;
      byp_next   = byp_reg;
      bs_next    = bs_reg;
      pre_next   = pre_reg;
      if (rise) begin
         st_next = nxt(st_reg, tms_s);
         case (st_reg)
            bst_pkg::ST_CAPIR: ir_sh_next = bst_pkg::IR_CAPTURE;
            bst_pkg::ST_SHIR:  ir_sh_next = {tdi_s, ir_sh_reg[bst_pkg::IR_W-1:1]};
            bst_pkg::ST_UPIR:  ir_next = ir_sh_reg;
            bst_pkg::ST_CAPDR: begin
               // only the selected register captures
               case (ir_reg)
                  bst_pkg::INS_IDCODE: id_next = bst_pkg::ID_CODE;
                  bst_pkg::INS_BYPASS: byp_next = bst_pkg::BYP_CAPTURE;
                  default:             bs_next = b2_reg;
               endcase
            end
            bst_pkg::ST_SHDR: begin
               case (ir_reg)
                  bst_pkg::INS_IDCODE: id_next = {tdi_s, id_reg[bst_pkg::ID_W-1:1]};
                  bst_pkg::INS_BYPASS: byp_next = tdi_s;
                  default:             bs_next = {tdi_s, bs_reg[bst_pkg::BSR_W-1:1]};
               endcase
            end
            bst_pkg::ST_UPDR: begin
               if (ir_reg == bst_pkg::INS_EXTEST || ir_reg == bst_pkg::INS_SAMPLE)
                  pre_next = bs_reg;
            end
            default: ;  // other states hold
         endcase
         // entering test reset restores identify at once, not one edge later
         if (st_next == bst_pkg::ST_RESET) begin
            ir_next  = bst_pkg::INS_IDCODE;
            pre_next = '1;                   // output-enable cell preset high
         end
      end
   end

   // falling edge launches serial output from selected lsb
   always_comb begin
      tdo_next = tdo_reg;
      oe_next  = oe_reg;
      if (fall) begin
         oe_next = (st_reg == bst_pkg::ST_SHDR) || (st_reg == bst_pkg::ST_SHIR);
         if (st_reg == bst_pkg::ST_SHIR)
            tdo_next = ir_sh_reg[0];
         else if (ir_reg == bst_pkg::INS_IDCODE)
            tdo_next = id_reg[0];
         else if (ir_reg == bst_pkg::INS_BYPASS)
            tdo_next = byp_reg;
         else
            tdo_next = bs_reg[0];
      end
   end

   // state registers; power-up reset lands in test reset, driver off
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg    <= bst_pkg::ST_RESET;
         ir_sh_reg <= '0;
         ir_reg    <= bst_pkg::INS_IDCODE;
         id_reg    <= '0;
         byp_reg   <= 1'b0;
         bs_reg    <= '0;
         pre_reg   <= '1;
         tdo_reg   <= 1'b0;
         oe_reg    <= 1'b0;
      end else begin
         st_reg    <= st_next;
         ir_sh_reg <= ir_sh_next;
         ir_reg    <= ir_next;
         id_reg    <= id_next;
         byp_reg   <= byp_next;
         bs_reg    <= bs_next;
         pre_reg   <= pre_next;
         tdo_reg   <= tdo_next;
         oe_reg    <= oe_next;
      end
   end

   // outputs; memory path only sees these, never reset by the port
   assign tdo_o    = tdo_reg;
   assign tdo_oe   = oe_reg;
   assign instr    = ir_reg;
   assign bsr_out  = pre_reg;
   assign outs_off = (ir_reg == bst_pkg::INS_SAMPZ) ||
                     (ir_reg == bst_pkg::INS_EXTEST && !pre_reg[bst_pkg::BSR_W-1]);

   // checks
   sequence tms_high_rise;
      rise && tms_s;
   endsequence

   // helper: run of rising test clock edges with mode select high, saturating
   logic [2:0] hi_cnt_reg, hi_cnt_next;

   // run length next value; a low mode select ends the run
   always_comb begin
      hi_cnt_next = hi_cnt_reg;
      if (rise) begin
         if (!tms_s)
            hi_cnt_next = 3'h0;
         else if (hi_cnt_reg != bst_pkg::RST_HIGHS)
            hi_cnt_next = hi_cnt_reg + 3'h1;
      end
   end

   // run length register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         hi_cnt_reg <= 3'h0;
      else
         hi_cnt_reg <= hi_cnt_next;
   end

   sequence fifth_high_rise;
      (hi_cnt_reg >= bst_pkg::RST_HIGHS - 3'h1) ##0 tms_high_rise;
   endsequence

   five_tms_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      fifth_high_rise |=> st_reg == bst_pkg::ST_RESET)
      else $error("five high edges missed reset");
   reset_walk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rise && tms_s && st_reg == bst_pkg::ST_SELIR) |=> st_reg == bst_pkg::ST_RESET)
      else $error("select-ir with mode high did not reset");
   oe_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      fall |=> tdo_oe == $past(st_reg == bst_pkg::ST_SHDR || st_reg == bst_pkg::ST_SHIR))
      else $error("driver on outside shift");
   tdo_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $changed(tdo_reg) |-> $past(fall)) else $error("output moved off falling edge");
   state_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $changed(st_reg) |-> $past(rise)) else $error("state moved off rising edge");
   ir_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      st_reg == bst_pkg::ST_RESET |-> ir_reg == bst_pkg::INS_IDCODE)
      else $error("instruction not identify after reset");
   ir_capture_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rise && st_reg == bst_pkg::ST_CAPIR) |=> ir_sh_reg[1:0] == 2'h1)
      else $error("capture pattern wrong");
   id_capture_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rise && st_reg == bst_pkg::ST_CAPDR && ir_reg == bst_pkg::INS_IDCODE)
      |=> id_reg == bst_pkg::ID_CODE) else $error("identification not captured");
   bypass_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rise && st_reg == bst_pkg::ST_SHDR && ir_reg == bst_pkg::INS_BYPASS)
      |=> byp_reg == $past(tdi_s)) else $error("bypass stage wrong");
endmodule
`default_nettype wire

// [sim/bst_ctl_model.sv]
// test controller model: drives the test pins with a 32 ns test clock
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
   input  wire logic              core_clk, // bench clock, paces each step
   output var bst_pkg::bst_pins_s pins,     // pins toward the port
   input  wire logic              tdo_o,    // serial out value
   input  wire logic              tdo_oe    // serial out enable
);
   // test clock parked low outside steps, so the port never advances idly
   initial pins = 3'h3;
   // one 32 ns period from just after a core edge: set up, sample, rise, fall
   task automatic step(input logic m, input logic d, output logic t, output logic o);
      @(posedge core_clk);
      #1;
      pins.tms = m;
      pins.tdi = d;
      #6;
      t = tdo_o;
      o = tdo_oe;
      pins.tck = 1'b1;
      #16;
      pins.tck = 1'b0;
      #8;
   endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // one table row: instruction, data length, data in, data out, outputs off
   typedef struct {
      logic [2:0]  code;
      int          len;
      logic [31:0] din;
      logic [31:0] dout;
      logic        off;
   } bst_row_s;
   logic               core_clk = 1'b0;   // core clock
   logic               rst_n = 1'b0;      // power-up reset
   bst_pkg::bst_pins_s pins;              // pins from the model
   logic               tms_driven = 1'b1; // mode select pad driven
   logic               tdi_driven = 1'b1; // serial in pad driven
   logic [7:0]         bsr_pins = 8'h3C;  // pin ring pattern
   logic               tdo_o;             // serial out value
   logic               tdo_oe;            // serial out enable
   logic               outs_off;          // memory outputs off
   logic [2:0]         instr;             // active instruction
   logic [7:0]         bsr_out;           // preload pattern
   logic [31:0]        d;                 // scanned-out data
   int                 bad_count = 0;     // mismatches
   int                 tests_run = 0;     // comparisons
   // bypass row expects one zero then the input delayed a stage
   bst_row_s rows [5] = '{
      '{bst_pkg::INS_SAMPLE, 8, 32'hA5, 32'h3C, 1'b0},
      '{bst_pkg::INS_EXTEST, 8, 32'h7F, 32'h3C, 1'b1},
      '{bst_pkg::INS_SAMPZ, 8, 32'hFF, 32'h3C, 1'b1},
      '{bst_pkg::INS_BYPASS, 8, 32'hA5, 32'h4A, 1'b0},
      '{bst_pkg::INS_IDCODE, 32, 32'h0, bst_pkg::ID_CODE, 1'b0}};
   always #2 core_clk = ~core_clk;
   bst_tap u_bst_tap (.core_clk(core_clk), .rst_n(rst_n), .pins(pins),
      .tms_driven(tms_driven), .tdi_driven(tdi_driven), .bsr_pins(bsr_pins), .tdo_o(tdo_o),
      .tdo_oe(tdo_oe), .instr(instr), .outs_off(outs_off), .bsr_out(bsr_out));
   bst_ctl_model u_bst_ctl_model (.core_clk(core_clk), .pins(pins), .tdo_o(tdo_o),
      .tdo_oe(tdo_oe));
   // compare and count
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one test clock, output ignored
   task automatic tick(input logic m);
      logic t;
      logic o;
      u_bst_ctl_model.step(m, 1'b0, t, o);
   endtask
   // idle to shift, n bits lsb first, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic t;
      logic o;
      dout = '0;
      tick(1'b1);
      if (ir) tick(1'b1);
      tick(1'b0);
      tick(1'b0);
      for (int i = 0; i < n; i++) begin
         u_bst_ctl_model.step(i == n - 1, din[i], t, o);
         dout[i] = t;
         if (i == 0) chk("oe_shift", {31'h0, o}, 32'h1);
      end
      tick(1'b1);
      u_bst_ctl_model.step(1'b0, 1'b0, t, o);
      chk("oe_idle", {31'h0, o}, 32'h0);
   endtask
   // verdict and end of run
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #200000;
      chk("watchdog", 32'h0, 32'h1);
      close_out();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (40) @(posedge core_clk);
      #1;
      chk("oe_powerup", {31'h0, tdo_oe}, 32'h0);
      chk("instr_powerup", {29'h0, instr}, 32'h1);
      chk("bsr_out_powerup", {24'h0, bsr_out}, 32'hFF);
      $display("test powerup done");
      tick(1'b0);
      foreach (rows[r]) begin
         scan(1'b1, 3, {29'h0, rows[r].code}, d);
         chk("ir_capture", {30'h0, d[1:0]}, 32'h1);
         chk("instr", {29'h0, instr}, {29'h0, rows[r].code});
         scan(1'b0, rows[r].len, rows[r].din, d);
         chk("dr_out", d, rows[r].dout);
         chk("outs_off", {31'h0, outs_off}, {31'h0, rows[r].off});
         if (rows[r].code inside {bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPLE})
            chk("bsr_out", {24'h0, bsr_out}, rows[r].din);
         $display("test row %0d done", r);
      end
      // undriven serial in reads high through bypass
      scan(1'b1, 3, {29'h0, bst_pkg::INS_BYPASS}, d);
      @(posedge core_clk);
      #1 tdi_driven = 1'b0;
      scan(1'b0, 8, 32'h0, d);
      chk("tdi_pullup", d, 32'hFE);
      @(posedge core_clk);
      #1 tdi_driven = 1'b1;
      // undriven mode select reads high: five clocks reset the port
      @(posedge core_clk);
      #1 tms_driven = 1'b0;
      repeat (5) tick(1'b0);
      chk("tms_pullup", {29'h0, instr}, 32'h1);
      chk("bsr_out_reset", {24'h0, bsr_out}, 32'hFF);
      @(posedge core_clk);
      #1 tms_driven = 1'b1;
      $display("test pullups done");
      // four highs from shift leave the port alone, the fifth resets it
      tick(1'b0);
      scan(1'b1, 3, {29'h0, bst_pkg::INS_BYPASS}, d);
      tick(1'b1);
      tick(1'b0);
      tick(1'b0);
      repeat (4) tick(1'b1);
      chk("four_high", {29'h0, instr}, 32'h7);
      tick(1'b1);
      chk("five_high", {29'h0, instr}, 32'h1);
      chk("oe_after_reset", {31'h0, tdo_oe}, 32'h0);
      $display("test five high done");
      // power-up reset again in mid-shift: driver off, identify restored
      tick(1'b0);
      scan(1'b1, 3, {29'h0, bst_pkg::INS_BYPASS}, d);
      tick(1'b1);
      tick(1'b0);
      tick(1'b0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("oe_shift_mid", {31'h0, tdo_oe}, 32'h1);
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("oe_reset_mid", {31'h0, tdo_oe}, 32'h0);
      chk("instr_reset_mid", {29'h0, instr}, 32'h1);
      rst_n = 1'b1;
      repeat (4) @(posedge core_clk);
      tick(1'b0);
      scan(1'b0, 32, 32'h0, d);
      chk("id_after_reset", d, bst_pkg::ID_CODE);
      $display("test mid reset done");
      close_out();
   end
endmodule
`default_nettype wire
